// ### dtm_cfg.svh
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

// fixed slave address; DTM_SLAVE_ADDR_ALT is defined but the core never answers at it
`define DTM_SLAVE_ADDR 7'h4C
`define DTM_SLAVE_ADDR_ALT 7'h4D

// read command codes
`define DTM_RD_LTEMP 8'h00
`define DTM_RD_RTEMP_MSB 8'h01
`define DTM_RD_STATUS 8'h02
`define DTM_RD_CFG 8'h03
`define DTM_RD_RATE 8'h04
`define DTM_RD_LHIGH 8'h05
`define DTM_RD_LLOW 8'h06
`define DTM_RD_RHIGH 8'h07
`define DTM_RD_RLOW 8'h08
`define DTM_RD_RTEMP_LSB 8'h10

// write command codes
`define DTM_WR_CFG 8'h09
`define DTM_WR_RATE 8'h0A
`define DTM_WR_LHIGH 8'h0B
`define DTM_WR_LLOW 8'h0C
`define DTM_WR_RHIGH 8'h0D
`define DTM_WR_RLOW 8'h0E

// same code for read and write
`define DTM_RW_RCRIT 8'h19
`define DTM_RW_LCRIT 8'h20
`define DTM_RW_HYST 8'h21
`define DTM_RW_FILT 8'hBF

// power-up values
`define DTM_RST_ZERO 8'h00
`define DTM_RST_RATE 8'h08
`define DTM_RST_LCRIT 8'h55
`define DTM_RST_RCRIT 8'h6E
`define DTM_RST_HIGH 8'h46
`define DTM_RST_LOW 8'h00
`define DTM_RST_HYST 8'h0A

// remote diode fault codes
`define DTM_OPEN_CODE 8'h7F
`define DTM_SHORT_CODE 8'h80

// status bits
`define DTM_ST_BUSY 8'h80
`define DTM_ST_LHIGH 8'h40
`define DTM_ST_LLOW 8'h20
`define DTM_ST_RHIGH 8'h10
`define DTM_ST_RLOW 8'h08
`define DTM_ST_OPEN 8'h04
`define DTM_ST_RCRIT 8'h02
`define DTM_ST_LCRIT 8'h01
`define DTM_ST_LOCAL 8'h61
`define DTM_ST_REMOTE 8'h1E
`define DTM_ST_ALERT 8'h7B

// configuration bits
`define DTM_CFG_ALERT_MASK 8'h80
`define DTM_CFG_LCRIT_MASK 8'h20
`define DTM_CFG_RCRIT_MASK 8'h10

// timing
`define DTM_PAIR_TIME_NS 31250000
`define DTM_REF_PERIOD_NS 40
`define DTM_PAIR_CYCLES (`DTM_PAIR_TIME_NS / `DTM_REF_PERIOD_NS)
`define DTM_RATE_FULL 8'h08
`define DTM_BIT_LAST 3'h7
`define DTM_BYTES_MAX 2'h2

`endif

// ### dtm_pkg.sv
package dtm_pkg;

   // link-side byte engine
   typedef enum logic [2:0] {
      LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_RX, LK_RX_ACK, LK_TX, LK_TX_ACK
   } dtm_link_t;

   // conversion sequencer
   typedef enum logic [1:0] {
      CV_LOCAL, CV_REMOTE, CV_GAP
   } dtm_cv_t;

   typedef struct packed {
      logic done;
      logic remote;
   } dtm_conv_t;

   typedef struct packed {
      logic is_cmd;
      logic [7:0] data;
   } dtm_wr_evt_t;

   typedef struct packed {
      logic [7:0] crit;
      logic [7:0] high;
      logic [7:0] low;
   } dtm_limits_t;

   typedef struct packed {
      logic high;
      logic low;
      logic over;
      logic alarm;
   } dtm_cmp_t;

endpackage

// ### dtm_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module dtm_sync2 (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic d,
   output logic sync_q
);

   logic meta_q;

   // two-flop level synchroniser; meta_q feeds sync_q only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else if (clk_en) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

endmodule

`default_nettype wire

// ### dtm_conv_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_conv_seq
   import dtm_pkg::*;
#(
   parameter int unsigned PAIR_CYCLES = `DTM_PAIR_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] rate,
   output dtm_conv_t conv,
   output logic busy
);

   localparam logic [31:0] PAIR = 32'(PAIR_CYCLES);
   localparam logic [31:0] HALF = 32'(PAIR_CYCLES / 2);

   dtm_cv_t st_q;
   logic [31:0] cnt_q;
   logic [31:0] gap;

   // idle time between pairs; faster rates than one pair back to back saturate
   always_comb begin
      if (rate >= `DTM_RATE_FULL) begin
         gap = 32'h0;
      end else begin
         gap = 32'(PAIR * ((32'h1 << (`DTM_RATE_FULL - rate)) - 32'h1));
      end
   end

   // local then remote, each half of the pair time
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_q <= CV_LOCAL;
         cnt_q <= 32'h0;
         conv <= '0;
      end else if (clk_en) begin
         conv <= '0;
         case (st_q)
            CV_LOCAL: begin
               if (cnt_q >= HALF - 32'h1) begin
                  cnt_q <= 32'h0;
                  st_q <= CV_REMOTE;
                  conv <= '{done: 1'b1, remote: 1'b0};
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            CV_REMOTE: begin
               if (cnt_q >= HALF - 32'h1) begin
                  cnt_q <= 32'h0;
                  st_q <= (gap == 32'h0) ? CV_LOCAL : CV_GAP;
                  conv <= '{done: 1'b1, remote: 1'b1};
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            CV_GAP: begin
               if (cnt_q >= gap - 32'h1) begin
                  cnt_q <= 32'h0;
                  st_q <= CV_LOCAL;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            default: begin
               st_q <= CV_LOCAL;
               cnt_q <= 32'h0;
            end
         endcase
      end
   end

   assign busy = (st_q != CV_GAP);

endmodule

`default_nettype wire

// ### dtm_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_core
   import dtm_pkg::*;
#(
   parameter int unsigned PAIR_CYCLES = `DTM_PAIR_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic smb_clk,
   input wire logic smb_data_in,
   output logic smb_data_out,
   output logic smb_data_oe,
   input wire logic [7:0] local_adc,
   input wire logic [10:0] remote_adc,
   input wire logic diode_open,
   input wire logic diode_short,
   output logic alert_n_out,
   output logic alert_n_oe,
   output logic tcrit_n_out,
   output logic tcrit_n_oe,
   output logic conv_busy
);

   // ---------------- link domain (smb_clk) ----------------
   dtm_link_t lk_state_q;
   logic [2:0] lk_cnt_q;
   logic [7:0] lk_shift_q;
   logic [7:0] lk_tx_q;
   logic [1:0] lk_nbytes_q;
   logic lk_rw_q;
   logic lk_oe_q;
   logic lk_sda_rise_q;
   logic lk_wr_tgl_q;
   logic lk_rd_tgl_q;
   dtm_wr_evt_t lk_wr_evt_q;
   logic lk_start;
   logic lk_stop;
   logic lk_bit;
   logic lk_byte_end;
   logic [7:0] lk_byte;
   logic lk_addr_hit;

   // ---------------- reference domain ----------------
   logic [7:0] ptr_q;
   logic [7:0] cfg_q;
   logic [7:0] rate_q;
   logic [7:0] filt_q;
   logic [7:0] hyst_q;
   dtm_limits_t llim_q;
   dtm_limits_t rlim_q;
   logic [7:0] ltemp_q;
   logic [7:0] rtemp_msb_q;
   logic [7:0] rtemp_lsb_q;
   logic [7:0] stat_q;
   logic [7:0] cond_q;
   logic crit_l_q;
   logic crit_r_q;
   logic [7:0] rd_hold_q;
   logic [7:0] rd_mux;
   logic alert_oe_q;
   logic tcrit_oe_q;
   logic wr_tgl_s;
   logic rd_tgl_s;
   logic wr_seen_q;
   logic rd_seen_q;
   logic wr_evt;
   logic rd_evt;
   dtm_conv_t conv;
   logic busy;
   logic [7:0] r_msb;
   logic [7:0] r_lsb;
   dtm_cmp_t lcmp;
   dtm_cmp_t rcmp;
   logic [7:0] set_vec;
   logic [7:0] cond_new;

   // signed compare of one reading against its three limits
   function automatic dtm_cmp_t compare(input logic [7:0] t, input dtm_limits_t lim,
                                        input logic [7:0] hyst, input logic prev);
      logic signed [8:0] ts;
      logic signed [8:0] release_at;
      dtm_cmp_t c;
      ts = 9'(signed'(t));
      release_at = 9'(signed'(lim.crit)) - 9'(signed'(hyst));
      c.high = ts > 9'(signed'(lim.high));
      c.low = ts < 9'(signed'(lim.low));
      c.over = ts > 9'(signed'(lim.crit));
      // alarm holds inside the hysteresis band
      c.alarm = c.over | (prev & ~(ts < release_at));
      return c;
   endfunction

   // ================= link side =================
   // data sampled on the rising clock edge, acted on at the falling one
   always_ff @(posedge smb_clk or posedge reset) begin
      if (reset) begin
         lk_sda_rise_q <= 1'b1;
      end else begin
         lk_sda_rise_q <= smb_data_in;
      end
   end

   // data moving while the clock is high marks start or stop
   assign lk_start = lk_sda_rise_q & ~smb_data_in;
   assign lk_stop = ~lk_sda_rise_q & smb_data_in;
   assign lk_bit = ~lk_start & ~lk_stop;
   assign lk_byte = {lk_shift_q[6:0], lk_sda_rise_q};
   assign lk_byte_end = lk_bit & (lk_cnt_q == `DTM_BIT_LAST);
   assign lk_addr_hit = (lk_byte[7:1] == `DTM_SLAVE_ADDR);

   // byte engine; only drives data, the clock is never touched or held
   always_ff @(negedge smb_clk or posedge reset) begin
      if (reset) begin
         lk_state_q <= LK_IDLE;
         lk_cnt_q <= 3'h0;
         lk_shift_q <= 8'h00;
         lk_tx_q <= 8'h00;
         lk_nbytes_q <= 2'h0;
         lk_rw_q <= 1'b0;
         lk_oe_q <= 1'b0;
      end else if (lk_start) begin
         // start or repeated start from any state
         lk_state_q <= LK_ADDR;
         lk_cnt_q <= 3'h0;
         lk_nbytes_q <= 2'h0;
         lk_oe_q <= 1'b0;
      end else if (lk_stop) begin
         lk_state_q <= LK_IDLE;
         lk_oe_q <= 1'b0;
      end else begin
         case (lk_state_q)
            LK_IDLE: begin
               lk_oe_q <= 1'b0;
            end
            LK_ADDR: begin
               lk_shift_q <= lk_byte;
               lk_cnt_q <= lk_cnt_q + 3'h1;
               if (lk_byte_end) begin
                  lk_rw_q <= lk_byte[0];
                  lk_oe_q <= lk_addr_hit;
                  lk_state_q <= lk_addr_hit ? LK_ADDR_ACK : LK_IDLE;
               end
            end
            LK_ADDR_ACK: begin
               lk_cnt_q <= 3'h0;
               if (lk_rw_q) begin
                  // fetched byte is already settled in rd_hold_q
                  lk_tx_q <= {rd_hold_q[6:0], 1'b0};
                  lk_oe_q <= ~rd_hold_q[7];
                  lk_state_q <= LK_TX;
               end else begin
                  lk_oe_q <= 1'b0;
                  lk_state_q <= LK_RX;
               end
            end
            LK_RX: begin
               lk_shift_q <= lk_byte;
               lk_cnt_q <= lk_cnt_q + 3'h1;
               if (lk_byte_end) begin
                  // command byte, then one data byte; further bytes are refused
                  lk_oe_q <= (lk_nbytes_q < `DTM_BYTES_MAX);
                  lk_state_q <= (lk_nbytes_q < `DTM_BYTES_MAX) ? LK_RX_ACK : LK_IDLE;
                  if (lk_nbytes_q < `DTM_BYTES_MAX) begin
                     lk_nbytes_q <= lk_nbytes_q + 2'h1;
                  end
               end
            end
            LK_RX_ACK: begin
               lk_oe_q <= 1'b0;
               lk_cnt_q <= 3'h0;
               lk_state_q <= LK_RX;
            end
            LK_TX: begin
               lk_cnt_q <= lk_cnt_q + 3'h1;
               if (lk_cnt_q == `DTM_BIT_LAST) begin
                  lk_oe_q <= 1'b0;
                  lk_state_q <= LK_TX_ACK;
               end else begin
                  lk_oe_q <= ~lk_tx_q[7];
                  lk_tx_q <= {lk_tx_q[6:0], 1'b0};
               end
            end
            LK_TX_ACK: begin
               // ack repeats the held byte, nack ends the read
               lk_cnt_q <= 3'h0;
               if (~lk_sda_rise_q) begin
                  lk_tx_q <= {rd_hold_q[6:0], 1'b0};
                  lk_oe_q <= ~rd_hold_q[7];
                  lk_state_q <= LK_TX;
               end else begin
                  lk_oe_q <= 1'b0;
                  lk_state_q <= LK_IDLE;
               end
            end
            default: begin
               lk_state_q <= LK_IDLE;
               lk_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // events toward the reference domain: byte held stable, toggle flips
   always_ff @(negedge smb_clk or posedge reset) begin
      if (reset) begin
         lk_wr_tgl_q <= 1'b0;
         lk_rd_tgl_q <= 1'b0;
         lk_wr_evt_q <= '0;
      end else if (lk_byte_end) begin
         if (lk_state_q == LK_RX && lk_nbytes_q < `DTM_BYTES_MAX) begin
            lk_wr_evt_q <= '{is_cmd: (lk_nbytes_q == 2'h0), data: lk_byte};
            lk_wr_tgl_q <= ~lk_wr_tgl_q;
         end
         // read fetch requested one link cycle ahead of the first data bit
         if (lk_state_q == LK_ADDR && lk_addr_hit && lk_byte[0]) begin
            lk_rd_tgl_q <= ~lk_rd_tgl_q;
         end
      end
   end

   // open drain: the pin only ever pulls low
   assign smb_data_out = 1'b0;
   assign smb_data_oe = lk_oe_q;

   // ================= reference side =================
   dtm_sync2 u_wr_sync (
      .clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .d(lk_wr_tgl_q),
      .sync_q(wr_tgl_s)
   );

   dtm_sync2 u_rd_sync (
      .clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .d(lk_rd_tgl_q),
      .sync_q(rd_tgl_s)
   );

   dtm_conv_seq #(
      .PAIR_CYCLES(PAIR_CYCLES)
   ) u_seq (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .rate(rate_q),
      .conv(conv),
      .busy(busy)
   );

   // toggle edges become one-cycle events
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_seen_q <= 1'b0;
         rd_seen_q <= 1'b0;
      end else if (clk_en) begin
         wr_seen_q <= wr_tgl_s;
         rd_seen_q <= rd_tgl_s;
      end
   end

   assign wr_evt = clk_en & (wr_tgl_s ^ wr_seen_q);
   assign rd_evt = clk_en & (rd_tgl_s ^ rd_seen_q);

   // command pointer keeps the last command byte
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ptr_q <= `DTM_RST_ZERO;
      end else if (wr_evt && lk_wr_evt_q.is_cmd) begin
         ptr_q <= lk_wr_evt_q.data;
      end
   end

   // writable registers; data byte lands at the pointed location
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cfg_q <= `DTM_RST_ZERO;
         rate_q <= `DTM_RST_RATE;
         filt_q <= `DTM_RST_ZERO;
         hyst_q <= `DTM_RST_HYST;
         llim_q <= '{crit: `DTM_RST_LCRIT, high: `DTM_RST_HIGH, low: `DTM_RST_LOW};
         rlim_q <= '{crit: `DTM_RST_RCRIT, high: `DTM_RST_HIGH, low: `DTM_RST_LOW};
      end else if (wr_evt && !lk_wr_evt_q.is_cmd) begin
         case (ptr_q)
            `DTM_WR_CFG: cfg_q <= lk_wr_evt_q.data;
            `DTM_WR_RATE: rate_q <= lk_wr_evt_q.data;
            `DTM_WR_LHIGH: llim_q.high <= lk_wr_evt_q.data;
            `DTM_WR_LLOW: llim_q.low <= lk_wr_evt_q.data;
            `DTM_WR_RHIGH: rlim_q.high <= lk_wr_evt_q.data;
            `DTM_WR_RLOW: rlim_q.low <= lk_wr_evt_q.data;
            `DTM_RW_RCRIT: rlim_q.crit <= lk_wr_evt_q.data;
            `DTM_RW_LCRIT: llim_q.crit <= lk_wr_evt_q.data;
            `DTM_RW_HYST: hyst_q <= lk_wr_evt_q.data;
            `DTM_RW_FILT: filt_q <= lk_wr_evt_q.data;
            default: ;
         endcase
      end
   end

   // remote result or fault code for this conversion
   always_comb begin
      if (diode_open) begin
         r_msb = `DTM_OPEN_CODE;
         r_lsb = `DTM_RST_ZERO;
      end else if (diode_short) begin
         r_msb = `DTM_SHORT_CODE;
         r_lsb = `DTM_RST_ZERO;
      end else begin
         r_msb = remote_adc[10:3];
         r_lsb = {remote_adc[2:0], 5'h00};
      end
   end

   // fault codes go through the ordinary compares, no special path
   assign lcmp = compare(local_adc, llim_q, hyst_q, crit_l_q);
   assign rcmp = compare(r_msb, rlim_q, hyst_q, crit_r_q);

   // conditions and new flags from the conversion that just ended
   always_comb begin
      set_vec = 8'h00;
      cond_new = cond_q;
      if (conv.done && !conv.remote) begin
         set_vec = (lcmp.high ? `DTM_ST_LHIGH : 8'h00) | (lcmp.low ? `DTM_ST_LLOW : 8'h00)
                 | (lcmp.over ? `DTM_ST_LCRIT : 8'h00);
         cond_new = (cond_q & ~`DTM_ST_LOCAL) | set_vec;
      end else if (conv.done && conv.remote) begin
         set_vec = (rcmp.high ? `DTM_ST_RHIGH : 8'h00) | (rcmp.low ? `DTM_ST_RLOW : 8'h00)
                 | (rcmp.over ? `DTM_ST_RCRIT : 8'h00) | (diode_open ? `DTM_ST_OPEN : 8'h00);
         cond_new = (cond_q & ~`DTM_ST_REMOTE) | set_vec;
      end
   end

   // results stay zero until their first conversion
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ltemp_q <= `DTM_RST_ZERO;
         rtemp_msb_q <= `DTM_RST_ZERO;
         rtemp_lsb_q <= `DTM_RST_ZERO;
      end else if (clk_en && conv.done) begin
         if (conv.remote) begin
            rtemp_msb_q <= r_msb;
            rtemp_lsb_q <= r_lsb;
         end else begin
            ltemp_q <= local_adc;
         end
      end
   end

   // alarm state per reading, with hysteresis, updated per conversion
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         crit_l_q <= 1'b0;
         crit_r_q <= 1'b0;
         cond_q <= 8'h00;
      end else if (clk_en && conv.done) begin
         cond_q <= cond_new;
         if (conv.remote) begin
            crit_r_q <= rcmp.alarm;
         end else begin
            crit_l_q <= lcmp.alarm;
         end
      end
   end

   // sticky flags; a status read clears only what no longer holds, set wins
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stat_q <= `DTM_RST_ZERO;
      end else if (clk_en) begin
         if (rd_evt && ptr_q == `DTM_RD_STATUS) begin
            stat_q <= (set_vec | (stat_q & cond_new)) & ~`DTM_ST_BUSY;
         end else begin
            stat_q <= (set_vec | stat_q) & ~`DTM_ST_BUSY;
         end
      end
   end

   // read selection by pointer; unmapped codes read zero
   always_comb begin
      case (ptr_q)
         `DTM_RD_LTEMP: rd_mux = ltemp_q;
         `DTM_RD_RTEMP_MSB: rd_mux = rtemp_msb_q;
         `DTM_RD_STATUS: rd_mux = stat_q | (busy ? `DTM_ST_BUSY : 8'h00);
         `DTM_RD_CFG: rd_mux = cfg_q;
         `DTM_RD_RATE: rd_mux = rate_q;
         `DTM_RD_LHIGH: rd_mux = llim_q.high;
         `DTM_RD_LLOW: rd_mux = llim_q.low;
         `DTM_RD_RHIGH: rd_mux = rlim_q.high;
         `DTM_RD_RLOW: rd_mux = rlim_q.low;
         `DTM_RD_RTEMP_LSB: rd_mux = rtemp_lsb_q;
         `DTM_RW_RCRIT: rd_mux = rlim_q.crit;
         `DTM_RW_LCRIT: rd_mux = llim_q.crit;
         `DTM_RW_HYST: rd_mux = hyst_q;
         `DTM_RW_FILT: rd_mux = filt_q;
         default: rd_mux = `DTM_RST_ZERO;
      endcase
   end

   // byte snapshot for the link; frozen between fetches so it crosses cleanly
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_hold_q <= `DTM_RST_ZERO;
      end else if (rd_evt) begin
         rd_hold_q <= rd_mux;
      end
   end

   // pin drivers; open flag is left out of the alert term
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         alert_oe_q <= 1'b0;
         tcrit_oe_q <= 1'b0;
      end else if (clk_en) begin
         alert_oe_q <= ((stat_q & `DTM_ST_ALERT) != 8'h00) && ((cfg_q & `DTM_CFG_ALERT_MASK) == 8'h00);
         tcrit_oe_q <= (crit_l_q && ((cfg_q & `DTM_CFG_LCRIT_MASK) == 8'h00))
                     || (crit_r_q && ((cfg_q & `DTM_CFG_RCRIT_MASK) == 8'h00));
      end
   end

   assign alert_n_out = 1'b0;
   assign alert_n_oe = alert_oe_q;
   assign tcrit_n_out = 1'b0;
   assign tcrit_n_oe = tcrit_oe_q;
   assign conv_busy = busy;

endmodule

`default_nettype wire

// ### dtm_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module dtm_core_monitor #(
   parameter int unsigned PAIR_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic smb_clk,
   input wire logic smb_data_out,
   input wire logic smb_data_oe,
   input wire logic [7:0] local_adc,
   input wire logic [10:0] remote_adc,
   input wire logic diode_open,
   input wire logic diode_short,
   input wire logic alert_n_out,
   input wire logic alert_n_oe,
   input wire logic tcrit_n_out,
   input wire logic tcrit_n_oe,
   input wire logic conv_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   int unsigned up_q, hot_q, cool_q, short_q;
   // run lengths of held inputs; 27 cycles covers one pair plus pin latency
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         up_q <= 0;
         hot_q <= 0;
         cool_q <= 0;
         short_q <= 0;
      end else begin
         up_q <= up_q + 1;
         hot_q <= ($signed(local_adc) > 8'sh55) ? hot_q + 1 : 0;
         cool_q <= ($signed(local_adc) < 8'sh4B && $signed(remote_adc[10:3]) < 8'sh64 && !diode_open) ?
            cool_q + 1 : 0;
         short_q <= (diode_short && !diode_open) ? short_q + 1 : 0;
      end
   end
   pins_low_a: assert property (!smb_data_out && !alert_n_out && !tcrit_n_out)
      else $error("drain level not low");
   reset_out_a: assert property ($fell(reset) |-> !alert_n_oe && !tcrit_n_oe && !smb_data_oe && conv_busy)
      else $error("bad outputs after reset");
   first_conv_a: assert property (up_q < PAIR_CYCLES / 2 |-> !alert_n_oe && !tcrit_n_oe)
      else $error("pin active before first conversion");
   no_gap_a: assert property (conv_busy)
      else $error("gap at full rate");
   hot_crit_a: assert property (hot_q > 26 |-> tcrit_n_oe)
      else $error("critical pin idle");
   cool_crit_a: assert property (cool_q > 26 |-> !tcrit_n_oe)
      else $error("critical pin stuck");
   short_alert_a: assert property (short_q > 26 |-> alert_n_oe)
      else $error("alert idle on short");
   bit_hold_a: assert property (smb_clk && $past(smb_clk) |-> $stable(smb_data_oe))
      else $error("data moved with clock high");
endmodule

bind dtm_core dtm_core_monitor #(.PAIR_CYCLES(PAIR_CYCLES)) mon_u (.ref_clk, .reset, .smb_clk, .smb_data_out,
   .smb_data_oe, .local_adc, .remote_adc, .diode_open, .diode_short, .alert_n_out, .alert_n_oe, .tcrit_n_out,
   .tcrit_n_oe, .conv_busy);

`default_nettype wire

// ### dtm_smb_host.sv
`timescale 1ns/100ps
`default_nettype none

module dtm_smb_host (
   output logic scl,
   output logic pull,
   input wire logic sda
);
   // released bus, clock starts high; after each stop it parks low
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic put(input logic b);
      pull = !b;
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
   endtask
   task automatic get(output logic b);
      pull = 1'b0;
      #40 scl = 1'b1;
      #40 b = sda;
      #40 scl = 1'b0;
      #40;
   endtask
   // also serves as repeated start
   task automatic start();
      pull = 1'b0;
      #40 scl = 1'b1;
      #40 pull = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask
   // clock parks low after the stop so the slave sees it on a falling edge
   task automatic stop();
      pull = 1'b1;
      #40 scl = 1'b1;
      #40 pull = 1'b0;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic tx(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) put(d[i]);
      get(nak);
   endtask
   // last byte always ends with a not-acknowledge
   task automatic rx(output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(1'b1);
   endtask
endmodule

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end

module tb_top;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] local_adc = 8'h00;
   logic [10:0] remote_adc = 11'h000;
   logic diode_open = 1'b0;
   logic diode_short = 1'b0;
   logic [31:0] v;
   logic [15:0] w;
   logic [2:0] k;
   wire scl, pull, oe, alert_oe, tcrit_oe;
   wire sda = !(pull || oe);
   int seed = 56766;
   int bad_count = 0;
   int checks_done = 0;
   logic [15:0] dflt [15] = '{16'h0000, 16'h0100, 16'h0280, 16'h0300, 16'h0408, 16'h0546, 16'h0600,
      16'h0746, 16'h0800, 16'h1000, 16'h196E, 16'h2055, 16'h210A, 16'hBF00, 16'h3000};
   logic [19:0] crit_tab [6] = '{20'h56001, 20'h4C001, 20'h4A000, 20'h006F1, 20'h006A1, 20'h00630};
   always #20 ref_clk = !ref_clk;
   dtm_smb_host host_u (.scl, .pull, .sda);
   dtm_core #(.PAIR_CYCLES(20)) dut_u (.ref_clk, .reset, .clk_en(1'b1), .smb_clk(scl), .smb_data_in(sda),
      .smb_data_out(), .smb_data_oe(oe), .local_adc, .remote_adc, .diode_open, .diode_short, .alert_n_out(),
      .alert_n_oe(alert_oe), .tcrit_n_out(), .tcrit_n_oe(tcrit_oe), .conv_busy());
   function automatic logic [15:0] word_of(input logic [10:0] r);
      return {r, 5'h00};
   endfunction
   // hold new sensor inputs long enough for a full pair to land
   task automatic drive(input logic [7:0] l, input logic [10:0] r, input logic o, input logic s);
      @(posedge ref_clk);
      #1 local_adc = l;
      remote_adc = r;
      diode_open = o;
      diode_short = s;
      repeat (30) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      host_u.start();
      host_u.tx(8'h98, k[2]);
      host_u.tx(c, k[1]);
      host_u.tx(d, k[0]);
      host_u.stop();
      `CHK("write acks", 3'h0, k)
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      host_u.start();
      host_u.tx(8'h98, k[2]);
      host_u.tx(c, k[1]);
      host_u.start();
      host_u.tx(8'h99, k[0]);
      host_u.rx(d);
      host_u.stop();
      `CHK("read acks", 3'h0, k)
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
      logic [7:0] d;
      rd(c, d);
      `CHK("register", e, d)
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // two milliseconds covers all traffic with wide margin
   initial begin
      #2000000;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #1 reset = 1'b0;
      foreach (dflt[i]) rd_chk(dflt[i][15:8], dflt[i][7:0]);
      drive(8'hE7, 11'h738, 1'b0, 1'b0);
      rd_chk(8'h00, 8'hE7);
      rd_chk(8'h01, 8'hE7);
      // random readings; high limit kept at or above 40h for later steps
      repeat (6) begin
         v = $random(seed);
         drive(v[7:0], v[18:8], 1'b0, 1'b0);
         w = word_of(v[18:8]);
         rd_chk(8'h00, v[7:0]);
         rd_chk(8'h01, w[15:8]);
         rd_chk(8'h10, w[7:0]);
         wr(8'h0B, {2'b01, v[29:24]});
         rd_chk(8'h05, {2'b01, v[29:24]});
      end
      host_u.start();
      host_u.tx(8'h9A, k[0]);
      host_u.stop();
      host_u.start();
      host_u.tx(8'h98, k[1]);
      host_u.tx(8'h0C, k[1]);
      host_u.tx(8'h33, k[1]);
      host_u.tx(8'h44, k[2]);
      host_u.stop();
      `CHK("refusals", 3'h5, k)
      rd_chk(8'h06, 8'h33);
      host_u.start();
      host_u.tx(8'h99, k[0]);
      host_u.rx(v[7:0]);
      host_u.stop();
      `CHK("bare read", 8'h33, v[7:0])
      foreach (crit_tab[i]) begin
         drive(crit_tab[i][19:12], {crit_tab[i][11:4], 3'h0}, 1'b0, 1'b0);
         `CHK("critical pin", crit_tab[i][0], tcrit_oe)
         if (i == 0) begin
            rd(8'h02, v[7:0]);
            `CHK("critical flag", 8'h01, v[7:0] & 8'h01)
         end
      end
      rd(8'h02, v[7:0]);
      `CHK("latched flags", 8'h03, v[7:0] & 8'h03)
      rd(8'h02, v[7:0]);
      `CHK("cleared flags", 8'h00, v[7:0] & 8'h03)
      `CHK("alert pin", 1'b1, alert_oe)
      wr(8'h09, 8'h80);
      `CHK("alert pin", 1'b0, alert_oe)
      wr(8'h09, 8'h00);
      `CHK("alert pin", 1'b1, alert_oe)
      drive(8'h40, 11'h000, 1'b1, 1'b0);
      rd_chk(8'h01, 8'h7F);
      rd_chk(8'h10, 8'h00);
      rd(8'h02, v[7:0]);
      `CHK("remote flags", 8'h16, v[7:0] & 8'h1E)
      `CHK("pins", 2'h3, {alert_oe, tcrit_oe})
      drive(8'h40, 11'h000, 1'b0, 1'b1);
      rd_chk(8'h01, 8'h80);
      rd(8'h02, v[7:0]);
      rd(8'h02, v[7:0]);
      `CHK("remote flags", 8'h08, v[7:0] & 8'h1E)
      // limits at the open code, so only the open flag remains
      drive(8'h40, 11'h000, 1'b0, 1'b0);
      wr(8'h0D, 8'h7F);
      wr(8'h19, 8'h7F);
      drive(8'h40, 11'h000, 1'b1, 1'b0);
      rd(8'h02, v[7:0]);
      rd(8'h02, v[7:0]);
      `CHK("open flag", 8'h04, v[7:0] & 8'h1E)
      `CHK("pins", 2'h0, {alert_oe, tcrit_oe})
      conclude();
   end
endmodule

`default_nettype wire
